// File: core/pcb_pkg.sv
// Constants, register map and state types for the priority backoff block
package pcb_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SLOT = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_BOCNT = 8'h10;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_PRIO_EN = 0;
	localparam int CTRL_BEACON = 1;
	localparam int CTRL_ALOHA = 2;
	localparam int CTRL_RELAYED_SLOT_LINK_NETWORK = 3;
	localparam int CTRL_GRADE = 4;
	localparam int CTRL_MINBE = 8;
	localparam int CMD_START = 0;
	localparam int CMD_PRIO = 1;
	localparam int CMD_ABORT = 2;

	// ---------------------------------------------------------------
	// Reset values and limits
	// ---------------------------------------------------------------
	localparam logic [3:0] MIN_BE_RST = 4'h2;
	localparam logic [3:0] MAX_BE = 4'h5;
	localparam logic [3:0] MAX_RETRY = 4'h4;
	localparam logic [7:0] PRIO_SLOTS = 8'h02;
	localparam logic [15:0] SLOT_RST = 16'h0040;
	localparam logic [15:0] LFSR_RST = 16'hACE1;

	// ---------------------------------------------------------------
	// Access grades and slot kinds
	// ---------------------------------------------------------------
	localparam logic [1:0] GRADE_0 = 2'h0;
	localparam logic [1:0] GRADE_1 = 2'h1;
	localparam logic [1:0] GRADE_2 = 2'h2;
	localparam logic [1:0] KIND_PRIO = 2'h0;
	localparam logic [1:0] KIND_PRIM = 2'h1;
	localparam logic [1:0] KIND_SUPP = 2'h2;
	localparam logic [1:0] KIND_OTHER = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_BACKOFF = 3'h3,
		ST_CCA = 3'h2,
		ST_TX = 3'h6,
		ST_RES = 3'h7
	} pcb_state_t;

	typedef struct packed {
		pcb_state_t st;
		logic prio_en;
		logic beacon;
		logic aloha;
		logic relayed_slot_link_network;
		logic [1:0] grade;
		logic [3:0] min_be;
		logic [15:0] slot_len;
		logic prio_f;
		logic fail_once;
		logic [3:0] be;
		logic [3:0] retry;
		logic [15:0] bo_cnt;
		logic [15:0] idle_tmr;
		logic [15:0] tmr;
		logic [7:0] slot_idx;
		logic [15:0] lfsr;
		logic tx_start;
		logic done;
		logic fail;
		logic busy;
		logic prio_slot;
		logic [31:0] rdata;
	} pcb_reg_t;

endpackage : pcb_pkg

// File: core/pcb_backoff.sv
// Priority channel access and backoff controller: fixed window for priority frames, growing window for normal frames
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

module pcb_backoff import pcb_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o,
	// Channel and timebase
	input wire logic beacon_i,
	input wire logic cca_busy_i,
	input wire logic slot_start_i,
	input wire logic [1:0] slot_kind_i,
	// Transmitter
	input wire logic tx_done_i,
	input wire logic tx_ok_i,
	output logic tx_start_o,
	// Status
	output logic busy_o,
	output logic done_o,
	output logic fail_o,
	output logic prio_slot_o
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] bo_mask(input logic [3:0] be);
		bo_mask = (16'h0001 << be) - 16'h0001;
	endfunction : bo_mask

	pcb_reg_t q;
	pcb_reg_t d;

	logic cmd_wr;
	logic slot_end;
	logic idle_slot;
	logic sel_slot;
	logic [15:0] draw;
	logic [31:0] stat;

	assign cmd_wr = we_i && (addr_i == OFS_CMD);
	assign slot_end = (q.tmr >= q.slot_len - 16'h0001);
	assign idle_slot = (q.idle_tmr >= q.slot_len - 16'h0001);
	assign draw = q.lfsr & bo_mask(q.be);
	assign stat = {8'h00, q.slot_idx, 3'h0, q.prio_slot, q.retry, q.be, 1'h0, q.st};

	// Eligible RELAYED_SLOT_LINK_NETWORK slot for the configured grade
	always_comb begin
		sel_slot = 1'b0;
		case (q.grade)
			GRADE_0: begin
				// Retry takes whichever prioritized or bidirectional slot comes first
				sel_slot = (slot_kind_i == KIND_PRIO) ||
					(q.fail_once && slot_kind_i != KIND_OTHER);
			end
			GRADE_1: begin
				sel_slot = (slot_kind_i == KIND_PRIM) ||
					(q.fail_once && slot_kind_i == KIND_SUPP);
			end
			GRADE_2: begin
				sel_slot = (slot_kind_i == KIND_PRIM) || (slot_kind_i == KIND_SUPP);
			end
			default: begin
				sel_slot = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		d.tx_start = 1'b0;
		d.done = 1'b0;
		d.fail = 1'b0;
		d.rdata = 32'h0000_0000;
		d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};

		// Slot timebase, realigned by every beacon / CAP start
		if (beacon_i) begin
			d.tmr = 16'h0000;
			d.slot_idx = 8'h00;
		end else if (slot_end) begin
			d.tmr = 16'h0000;
			if (q.slot_idx != 8'hFF) begin
				d.slot_idx = q.slot_idx + 8'h01;
			end
		end else begin
			d.tmr = q.tmr + 16'h0001;
		end
		d.prio_slot = q.beacon && q.prio_en && (d.slot_idx < PRIO_SLOTS);

		// Register writes
		if (we_i && addr_i == OFS_CTRL) begin
			d.prio_en = wdata_i[CTRL_PRIO_EN];
			d.beacon = wdata_i[CTRL_BEACON];
			d.aloha = wdata_i[CTRL_ALOHA];
			d.relayed_slot_link_network = wdata_i[CTRL_RELAYED_SLOT_LINK_NETWORK];
			d.grade = wdata_i[CTRL_GRADE +: 2];
			d.min_be = wdata_i[CTRL_MINBE +: 4];
		end
		if (we_i && addr_i == OFS_SLOT) begin
			// Zero would wrap to a 65536-cycle slot; clamp to one cycle
			d.slot_len = (wdata_i[15:0] == 16'h0000) ? 16'h0001 : wdata_i[15:0];
		end

		// Register reads, answered in the next cycle
		if (re_i) begin
			case (addr_i)
				OFS_CTRL: begin
					d.rdata = {20'h00000, q.min_be, 2'h0, q.grade, q.relayed_slot_link_network, q.aloha, q.beacon, q.prio_en};
				end
				OFS_SLOT: begin
					d.rdata = {16'h0000, q.slot_len};
				end
				OFS_STAT: begin
					d.rdata = stat;
				end
				OFS_BOCNT: begin
					d.rdata = {16'h0000, q.bo_cnt};
				end
				default: begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Access state machine
		case (q.st)
			ST_IDLE: begin
				if (cmd_wr && wdata_i[CMD_START]) begin
					d.prio_f = wdata_i[CMD_PRIO] && q.prio_en;
					d.retry = 4'h0;
					d.fail_once = 1'b0;
					if (wdata_i[CMD_PRIO] && q.prio_en) begin
						d.be = q.min_be - 4'h1;
					end else begin
						d.be = q.min_be;
					end
					d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (q.relayed_slot_link_network) begin
					if (slot_start_i && sel_slot) begin
						// Supplementary slots are contended, so assess first
						d.st = (slot_kind_i == KIND_SUPP) ? ST_CCA : ST_TX;
					end
				end else if (!q.beacon || q.prio_f || !q.prio_en || q.slot_idx >= PRIO_SLOTS) begin
					// Priority frames go at once, in or out of the priority slots
					d.bo_cnt = draw;
					d.idle_tmr = 16'h0000;
					d.st = ST_BACKOFF;
				end
			end
			ST_BACKOFF: begin
				if (q.bo_cnt == 16'h0000) begin
					d.st = q.aloha ? ST_TX : ST_CCA;
				end else if (cca_busy_i && q.prio_f && !q.aloha) begin
					// Persistent sensing: a busy channel restarts the idle slot
					d.idle_tmr = 16'h0000;
				end else if (idle_slot) begin
					d.idle_tmr = 16'h0000;
					d.bo_cnt = q.bo_cnt - 16'h0001;
				end else begin
					d.idle_tmr = q.idle_tmr + 16'h0001;
				end
			end
			ST_CCA: begin
				if (!cca_busy_i) begin
					d.st = ST_TX;
				end else if (q.retry == MAX_RETRY) begin
					d.fail = 1'b1;
					d.st = ST_IDLE;
				end else begin
					d.retry = q.retry + 4'h1;
					d.fail_once = 1'b1;
					// Priority frames hold the exponent; normal frames grow it
					if (!q.prio_f && q.be < MAX_BE) begin
						d.be = q.be + 4'h1;
					end
					d.st = ST_WAIT;
				end
			end
			ST_TX: begin
				d.tx_start = 1'b1;
				d.st = ST_RES;
			end
			ST_RES: begin
				if (tx_done_i && tx_ok_i) begin
					d.done = 1'b1;
					d.st = ST_IDLE;
				end else if (tx_done_i && q.retry == MAX_RETRY) begin
					d.fail = 1'b1;
					d.st = ST_IDLE;
				end else if (tx_done_i) begin
					d.retry = q.retry + 4'h1;
					d.fail_once = 1'b1;
					if (!q.prio_f && q.be < MAX_BE) begin
						d.be = q.be + 4'h1;
					end
					d.st = ST_WAIT;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		if (cmd_wr && wdata_i[CMD_ABORT]) begin
			d.st = ST_IDLE;
		end
		d.busy = (d.st != ST_IDLE);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.min_be <= MIN_BE_RST;
			q.slot_len <= SLOT_RST;
			q.lfsr <= LFSR_RST;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign tx_start_o = q.tx_start;
	assign busy_o = q.busy;
	assign done_o = q.done;
	assign fail_o = q.fail;
	assign prio_slot_o = q.prio_slot;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_tx_pulse;
		tx_start_o ##1 !tx_start_o;
	endsequence

	property p_first_be;
		q.st == ST_IDLE && cmd_wr && wdata_i[CMD_START] && wdata_i[CMD_PRIO] && q.prio_en
			|=> q.be == $past(q.min_be) - 4'h1 && q.prio_f;
	endproperty
	a_first_be: assert property (p_first_be) else $error("first priority exponent wrong");

	property p_be_const;
		q.prio_f && q.st != ST_IDLE && $past(q.st) != ST_IDLE |-> q.be == $past(q.be);
	endproperty
	a_be_const: assert property (p_be_const) else $error("priority exponent changed");

	property p_reserve;
		q.st == ST_BACKOFF && $past(q.st) == ST_WAIT && !q.prio_f && q.beacon && q.prio_en
			|-> $past(q.slot_idx) >= PRIO_SLOTS;
	endproperty
	a_reserve: assert property (p_reserve) else $error("normal frame in priority slot");

	property p_bo_range;
		q.st == ST_BACKOFF && $past(q.st) == ST_WAIT |-> q.bo_cnt <= bo_mask(q.be);
	endproperty
	a_bo_range: assert property (p_bo_range) else $error("backoff count out of window");

	property p_persist;
		q.st == ST_BACKOFF && q.prio_f && !q.aloha && cca_busy_i && q.bo_cnt != 16'h0000
			|=> q.idle_tmr == 16'h0000 && q.bo_cnt == $past(q.bo_cnt);
	endproperty
	a_persist: assert property (p_persist) else $error("count moved while busy");

	property p_busy_retry;
		q.st == ST_CCA && cca_busy_i && q.prio_f && q.retry != MAX_RETRY
			|=> q.st == ST_WAIT ##1 q.st == ST_BACKOFF || q.relayed_slot_link_network;
	endproperty
	a_busy_retry: assert property (p_busy_retry) else $error("busy did not re-backoff");

	property p_tx;
		q.st == ST_TX |=> s_tx_pulse;
	endproperty
	a_tx: assert property (p_tx) else $error("transmit strobe not one cycle");

	property p_unslotted;
		q.st == ST_WAIT && !q.relayed_slot_link_network && !q.beacon |=> q.st == ST_BACKOFF;
	endproperty
	a_unslotted: assert property (p_unslotted) else $error("unslotted start delayed");

	property p_grade0;
		q.st == ST_WAIT && q.relayed_slot_link_network && q.grade == GRADE_0 && slot_start_i && slot_kind_i == KIND_PRIO
			|=> q.st == ST_TX ##1 tx_start_o;
	endproperty
	a_grade0: assert property (p_grade0) else $error("grade 0 missed prioritized slot");

	property p_grade1;
		q.st == ST_WAIT && q.relayed_slot_link_network && q.grade == GRADE_1 && !q.fail_once && slot_start_i &&
			slot_kind_i != KIND_PRIM |=> q.st == ST_WAIT;
	endproperty
	a_grade1: assert property (p_grade1) else $error("grade 1 left before primary");

	// Any command write may abort, so the antecedent requires that no command write occurs
	property p_aloha_skip;
		q.st == ST_BACKOFF && q.aloha && q.bo_cnt == 16'h0000 && !cmd_wr |=> q.st == ST_TX;
	endproperty
	a_aloha_skip: assert property (p_aloha_skip) else $error("aloha frame waited for assessment");

	property p_slot_step;
		q.st == ST_BACKOFF && q.bo_cnt != 16'h0000 && q.idle_tmr < q.slot_len - 16'h0001
			|=> q.bo_cnt == $past(q.bo_cnt);
	endproperty
	a_slot_step: assert property (p_slot_step) else $error("count dropped before a full slot");

	property p_cap_reserve;
		beacon_i && q.beacon && q.prio_en |=> prio_slot_o;
	endproperty
	a_cap_reserve: assert property (p_cap_reserve) else $error("CAP start without priority slot");

endmodule : pcb_backoff

// File: verification/pcb_chan_model.sv
// Channel and transmitter model on the far side of the backoff block
`timescale 1ns/1ps

module pcb_chan_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench controls
	input wire logic busy_req_i,
	input wire logic ok_req_i,
	input wire logic [7:0] delay_i,
	// Block side
	input wire logic tx_start_i,
	output logic cca_busy_o,
	output logic tx_done_o,
	output logic tx_ok_o
);
	logic [7:0] cnt_q;
	logic act_q;

	assign cca_busy_o = busy_req_i;
	// Outside the done pulse the ok line shows the wrong answer
	assign tx_ok_o = tx_done_o ? ok_req_i : ~ok_req_i;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 8'h00;
			act_q <= 1'b0;
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= 1'b0;
			if (tx_start_i) begin
				act_q <= 1'b1;
				cnt_q <= delay_i;
			end else if (act_q && cnt_q == 8'h00) begin
				act_q <= 1'b0;
				tx_done_o <= 1'b1;
			end else if (act_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : pcb_chan_model

// File: verification/pcb_backoff_tb.sv
// Self-checking bench for the priority backoff block
`timescale 1ns/1ps

module pcb_backoff_tb import pcb_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic beacon_i = 1'b0;
	logic slot_start_i = 1'b0;
	logic [1:0] slot_kind_i = 2'h0;
	logic busy_req = 1'b0;
	logic ok_req = 1'b1;
	logic [7:0] delay = 8'h01;
	logic [31:0] rdata_o;
	logic cca_busy_i, tx_done_i, tx_ok_i, tx_start_o, busy_o, done_o, fail_o, prio_slot_o;
	// Pulses are counted, so one that fires before its wait starts is still seen
	logic [31:0] n_ev [3] = '{32'h0, 32'h0, 32'h0};
	logic [31:0] seen [3] = '{32'h0, 32'h0, 32'h0};
	logic [31:0] nt;
	logic [3:0] mb;
	logic [1:0] no_k [3] = '{KIND_PRIM, KIND_PRIO, KIND_PRIO};
	logic [1:0] go_k [3] = '{KIND_PRIO, KIND_PRIM, KIND_PRIM};
	logic [1:0] re_k [3] = '{KIND_PRIM, KIND_SUPP, KIND_SUPP};
	int fail_count = 0;
	int checks = 0;

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (tx_start_o === 1'b1)
			n_ev[0] <= n_ev[0] + 32'h1;
		if (done_o === 1'b1)
			n_ev[1] <= n_ev[1] + 32'h1;
		if (fail_o === 1'b1)
			n_ev[2] <= n_ev[2] + 32'h1;
	end

	pcb_backoff u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
		.re_i(re_i), .rdata_o(rdata_o), .beacon_i(beacon_i), .cca_busy_i(cca_busy_i),
		.slot_start_i(slot_start_i), .slot_kind_i(slot_kind_i), .tx_done_i(tx_done_i), .tx_ok_i(tx_ok_i),
		.tx_start_o(tx_start_o), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o), .prio_slot_o(prio_slot_o));

	pcb_chan_model u_chan (.clk_i(clk_i), .rst_i(rst_i), .busy_req_i(busy_req), .ok_req_i(ok_req),
		.delay_i(delay), .tx_start_i(tx_start_o), .cca_busy_o(cca_busy_i), .tx_done_o(tx_done_i),
		.tx_ok_o(tx_ok_i));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		// A command opens a new frame: events of earlier frames are spent
		if (a == OFS_CMD)
			seen = n_ev;
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string msg);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		chk(rdata_o & m, e, msg);
	endtask : rd

	task automatic pulse(input logic slot, input logic [1:0] k);
		@(posedge clk_i);
		beacon_i <= ~slot;
		slot_start_i <= slot;
		slot_kind_i <= k;
		@(posedge clk_i);
		beacon_i <= 1'b0;
		slot_start_i <= 1'b0;
	endtask : pulse

	// Bounded wait for the next unseen event: 0 tx start, 1 done, 2 fail
	task automatic wait_o(input int sel, input int lim);
		seen[sel] = seen[sel] + 32'h1;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_i);
			#1;
			if (n_ev[sel] >= seen[sel])
				return;
		end
		fail_count++;
		$display("mismatch at %0t: wait %0d timed out", $time, sel);
		print_verdict();
	endtask : wait_o

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFS_CTRL, 32'h0000_0200, 32'hFFFF_FFFF, "ctrl reset");
		rd(OFS_SLOT, {16'h0000, SLOT_RST}, 32'hFFFF_FFFF, "slot reset");
		rd(8'h14, 32'h0, 32'hFFFF_FFFF, "unmapped");
		wr(OFS_STAT, 32'hFFFF_FFFF);
		rd(OFS_STAT, 32'h0, 32'hFFFF_FFFF, "status");
		wr(OFS_SLOT, 32'h0000_0004);
		rd(OFS_SLOT, 32'h0000_0004, 32'hFFFF_FFFF, "slot");
		for (mb = 4'h2; mb < 4'h5; mb += 4'h2) begin
			wr(OFS_CTRL, {20'h0, mb, 8'h01});
			wr(OFS_CMD, 32'h3);
			rd(OFS_STAT, {24'h0, mb - 4'h1, 4'h0}, 32'hF0, "first exponent");
			chk(busy_o, 32'h1, "busy during frame");
			rd(OFS_BOCNT, 32'h0, 32'hFFFF_FFFF << (mb - 4'h1), "count range");
			wait_o(0, 200);
			wait_o(1, 50);
			chk(busy_o, 32'h0, "idle after done");
		end
		// Busy channel: hold off, then retries at a constant exponent
		// Wide window, so a zero draw that burns retries while busy is rare
		wr(OFS_CTRL, 32'h0000_0501);
		busy_req <= 1'b1;
		ok_req <= 1'b0;
		delay <= 8'h14;
		nt = n_ev[0];
		wr(OFS_CMD, 32'h3);
		repeat (40) @(posedge clk_i);
		chk(n_ev[0], nt, "sent on busy channel");
		busy_req <= 1'b0;
		wait_o(0, 100);
		wait_o(0, 300);
		rd(OFS_STAT, 32'h40, 32'hF0, "exponent held");
		wait_o(2, 3000);
		rd(OFS_STAT, 32'h0, 32'h7, "idle after fail");
		// Beacon mode: normal frame held, priority frame later in the CAP
		wr(OFS_CTRL, 32'h0000_0203);
		ok_req <= 1'b1;
		delay <= 8'h01;
		pulse(1'b0, KIND_OTHER);
		#1;
		chk(prio_slot_o, 32'h1, "priority slot");
		wr(OFS_CMD, 32'h1);
		repeat (2) @(posedge clk_i);
		rd(OFS_STAT, 32'h1, 32'h7, "normal frame waits");
		wait_o(0, 100);
		wait_o(1, 50);
		chk(prio_slot_o, 32'h0, "slot after reserve");
		wr(OFS_CMD, 32'h3);
		wait_o(0, 100);
		wait_o(1, 50);
		pulse(1'b0, KIND_OTHER);
		#1;
		chk(prio_slot_o, 32'h1, "next CAP reserve");
		// Aloha ignores the busy channel
		wr(OFS_CTRL, 32'h0000_0205);
		busy_req <= 1'b1;
		wr(OFS_CMD, 32'h3);
		wait_o(0, 100);
		wait_o(1, 50);
		@(posedge clk_i);
		busy_req <= 1'b0;
		// Slot-link grades, each first attempt failing
		ok_req <= 1'b0;
		for (int g = 0; g < 3; g++) begin
			wr(OFS_CTRL, 32'h0000_0209 | (32'(g) << 4));
			wr(OFS_CMD, 32'h3);
			nt = n_ev[0];
			pulse(1'b1, KIND_OTHER);
			pulse(1'b1, no_k[g]);
			repeat (10) @(posedge clk_i);
			chk(n_ev[0], nt, "sent in wrong slot");
			pulse(1'b1, go_k[g]);
			wait_o(0, 50);
			repeat (8) @(posedge clk_i);
			pulse(1'b1, re_k[g]);
			wait_o(0, 100);
			repeat (4) @(posedge clk_i);
			wr(OFS_CMD, 32'h4);
		end
		print_verdict();
	end
endmodule : pcb_backoff_tb
